// *** rtl/fbz_pkg.sv ***
// Summary of operation
// RQ1: jitter is applied only while running at maximum switching frequency.
// RQ2: default jitter is +/-3.125 percent over a 3.2 ms period; codes 5 and 3.
// RQ3: feedback below entry threshold enters burst mode and starts a burst-off phase.
// RQ4: entry threshold comes from a table indexed by zero-crossing voltage; lower vout, higher.
// RQ5: in burst, feedback above wake starts burst-on; reaching pause returns to burst-off.
// RQ6: after wake, wait 26.6 us before the first burst gate pulse.
// RQ7: burst-on cycles are predefined and independent of feedback; here burst-on ends on pause or exit feedback, bcnt_q only steps the peak.
// RQ8: burst pulses share one frequency; peak steps over four pulses, then holds; here bcnt_q wraps after 256 pulses and the peak restarts at BURST_PK0.
// RQ9: feedback above exit threshold leaves burst mode at once.
// RQ10: on exit, the next pulse uses the fixed exit peak, then the normal law; here a pulse already running ends ST_EXIT first.
// RQ11: in resonant mode an aux pulse and a dead time precede each main pulse.
// RQ12: in resonant mode the main switching period is set directly by the device.
// RQ13: after a zero crossing, the aux gate asserts once the configured delay expires.
// RQ14: the main gate pulse is only generated after a zero crossing was seen.
// RQ15: aux pulses are enabled by line voltage against a level with 20 V hysteresis.
// RQ16: dead time from aux end to main turn-on is fixed at 220 ns.
// RQ17: aux length is bulk times factor over 65536 times 15.15 ns plus 31.6 ns.
// RQ18: default aux scaling factor is 3200.
// RQ19: bulk value is derived from the bulk sense current with a 102 kohm resistor.
// RQ20: during burst-off and the wake delay both gates stay off.
package fbz_pkg;

	localparam int unsigned CLK_PS           = 8000;
	// timing in ps
	localparam int unsigned WAKE_DELAY_PS    = 26600000;
	localparam int unsigned DEAD_TIME_PS     = 220000;
	localparam int unsigned AUX_STEP_PS      = 15150;
	localparam int unsigned AUX_BASE_PS      = 31600;
	localparam int unsigned WAKE_CYC         = (WAKE_DELAY_PS + CLK_PS - 1) / CLK_PS;
	localparam int unsigned DEAD_CYC         = (DEAD_TIME_PS + CLK_PS - 1) / CLK_PS;
	localparam int unsigned AUX_BASE_CYC     = (AUX_BASE_PS + CLK_PS - 1) / CLK_PS;
	// jitter: codes as stored, amplitude 3.125 percent = 1/32
	localparam logic [3:0]  JIT_AMP_CODE     = 4'h5;
	localparam logic [3:0]  JIT_PER_CODE     = 4'h3;
	localparam int unsigned JIT_PERIOD_US    = 3200;
	// one triangle spans 256 steps; step length rounded to whole cycles
	localparam int unsigned JIT_STEP_CYC     = (JIT_PERIOD_US * 1000000 / CLK_PS + 128) / 256;
	localparam int unsigned JIT_AMP_SHIFT    = 5;
	// resonant pulse
	localparam logic [15:0] ZVS_FACTOR_RST   = 16'h0c80;
	localparam int unsigned RHV_KOHM         = 102;
	localparam logic [11:0] HYST_VOLTS       = 12'h014;
	// peak settings (arbitrary code units)
	localparam logic [7:0]  BURST_PK0        = 8'h20;
	localparam logic [7:0]  BURST_PK1        = 8'h30;
	localparam logic [7:0]  BURST_PK2        = 8'h40;
	localparam logic [7:0]  BURST_PK3        = 8'h50;
	localparam logic [7:0]  EXIT_PK          = 8'h60;
	localparam logic [15:0] BURST_PERIOD_RST = 16'h0320;
	localparam logic [7:0]  BURST_PULSES_RST = 8'h08;

	// register offsets (byte addresses)
	localparam logic [7:0]  REG_CTRL         = 8'h00;
	localparam logic [7:0]  REG_THRESH       = 8'h04;
	localparam logic [7:0]  REG_PERIOD       = 8'h08;
	localparam logic [7:0]  REG_ZVS          = 8'h0c;
	localparam logic [7:0]  REG_LINE         = 8'h10;
	localparam logic [7:0]  REG_STATUS       = 8'h14;
	localparam logic [31:0] CTRL_RST         = 32'h0000_0001;
	localparam logic [31:0] THRESH_RST       = 32'h00c0_30a0;
	localparam logic [31:0] PERIOD_RST       = 32'h0000_0382;
	localparam logic [31:0] LINE_RST         = 32'h0000_00a0;
	localparam logic [31:0] ZVS_RST          = 32'h0000_0c80;

	typedef enum logic [2:0] {
		ST_NORMAL   = 3'b000,
		ST_BOFF     = 3'b001,
		ST_WAKE     = 3'b010,
		ST_BON      = 3'b011,
		ST_EXIT     = 3'b100
	} fbz_mode_t;

	typedef enum logic [2:0] {
		PH_IDLE     = 3'b000,
		PH_WAITZC   = 3'b001,
		PH_ZDLY     = 3'b010,
		PH_AUX      = 3'b011,
		PH_DEAD     = 3'b100,
		PH_MAIN     = 3'b101
	} fbz_phase_t;

endpackage

// *** rtl/fbz_sync.sv ***
`timescale 1ns/1ps
module fbz_sync import fbz_pkg::*; #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_q, s2_q, s3_q, out_q;

	// first stage feeds only the second; change counts when stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			out_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					out_q[i] <= s3_q[i];
				end
			end
		end
	end
	assign dout = out_q;
endmodule

// *** rtl/fbz_gate_ctrl.sv ***
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module fbz_gate_ctrl import fbz_pkg::*; #(
	parameter int unsigned WAKE_CYCLES = WAKE_CYC,
	parameter int unsigned JIT_STEP_CYCLES = JIT_STEP_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// comparator and sense inputs from pins
	input  wire logic [7:0]  feedback_pin,
	input  wire logic [7:0]  zcd_level,
	input  wire logic        zero_cross,
	input  wire logic [11:0] bulk_sense_pin,
	input  wire logic        at_max_freq,
	// power stage gates
	output logic             main_gate_output,
	output logic             aux_gate_output,
	// peak current command and jittered period
	output logic      [7:0]  peak_setting,
	output logic      [15:0] period_out
);
	// ----------------------------------------------------------------
	// reset and input conditioning
	// ----------------------------------------------------------------
	logic rs1_q, rs2_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end
	wire logic rstn = rs2_q;

	logic [7:0]  fb, zl;
	logic        zc;
	logic [11:0] bulk_i;
	logic        amax;
	fbz_sync #(.W(30)) u_sync (
		.clk  (clk),
		.rst_n(rstn),
		.din  ({feedback_pin, zcd_level, zero_cross, bulk_sense_pin, at_max_freq}),
		.dout ({fb, zl, zc, bulk_i, amax})
	);

	// synchronised pins read zero until the pipeline fills; the mode machine
	// waits for that, so leaving reset cannot fake a burst entry
	logic [2:0] prime_q;
	wire logic  primed = prime_q[2];
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) prime_q <= '0;
		else if (!primed) prime_q <= prime_q + 3'h1;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q, thr_q, per_q, zvs_q, line_q;
	logic        ack_q;
	logic [31:0] rdat_q;
	wire logic   req = wb_cyc_i & wb_stb_i & ~ack_q;
	logic [31:0] st_word;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
		end
		return r;
	endfunction

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RST;
			thr_q  <= THRESH_RST;
			per_q  <= PERIOD_RST;
			zvs_q  <= ZVS_RST; // RQ18
			line_q <= LINE_RST;
		end else if (req && wb_we_i) begin
			case (wb_adr_i)
				REG_CTRL:   ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
				REG_THRESH: thr_q  <= merge(thr_q, wb_dat_i, wb_sel_i);
				REG_PERIOD: per_q  <= merge(per_q, wb_dat_i, wb_sel_i);
				REG_ZVS:    zvs_q  <= merge(zvs_q, wb_dat_i, wb_sel_i);
				REG_LINE:   line_q <= merge(line_q, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	// single wait-free answer: ack one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_q  <= 1'b0;
			rdat_q <= '0;
		end else begin
			ack_q <= req;
			if (req && !wb_we_i) begin
				case (wb_adr_i)
					REG_CTRL:   rdat_q <= ctrl_q;
					REG_THRESH: rdat_q <= thr_q;
					REG_PERIOD: rdat_q <= per_q;
					REG_ZVS:    rdat_q <= zvs_q;
					REG_LINE:   rdat_q <= line_q;
					REG_STATUS: rdat_q <= st_word;
					default:    rdat_q <= '0;
				endcase
			end
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	wire logic        res_en   = ctrl_q[0];
	wire logic        jit_en   = ctrl_q[1];
	wire logic [7:0]  wake_thr = thr_q[7:0];
	wire logic [7:0]  pause_th = thr_q[15:8];
	wire logic [7:0]  exit_thr = thr_q[23:16];
	wire logic [15:0] base_per = per_q[15:0];
	wire logic [15:0] zc_dly   = zvs_q[31:16];
	wire logic [15:0] kfac     = zvs_q[15:0];
	wire logic [11:0] line_lvl = line_q[11:0];

	// ----------------------------------------------------------------
	// burst entry table and mode machine
	// ----------------------------------------------------------------
	logic [7:0] entry_thr;
	always_comb begin
		// lower zero-crossing level means lower output voltage: higher entry point
		case (zl[7:6]) // RQ4
			2'b00:   entry_thr = 8'h30;
			2'b01:   entry_thr = 8'h28;
			2'b10:   entry_thr = 8'h20;
			default: entry_thr = 8'h18;
		endcase
	end

	fbz_mode_t   mode_q;
	logic [12:0] wake_q;
	logic [7:0]  bcnt_q;
	logic        cyc_end;
	logic        exit_used_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_q      <= ST_NORMAL;
			wake_q      <= '0;
			bcnt_q      <= '0;
			exit_used_q <= 1'b0;
		end else if (primed) begin
			if (mode_q != ST_NORMAL && mode_q != ST_EXIT && fb > exit_thr) begin
				mode_q      <= ST_EXIT; // RQ9
				exit_used_q <= 1'b0;
			end else begin
				case (mode_q)
					ST_NORMAL: if (fb < entry_thr) mode_q <= ST_BOFF; // RQ3
					ST_BOFF: begin
						if (fb > wake_thr) begin // RQ5
							mode_q <= ST_WAKE;
							wake_q <= '0;
						end
					end
					ST_WAKE: begin
						wake_q <= wake_q + 13'h1;
						if (wake_q == 13'(WAKE_CYCLES - 1)) begin // RQ6
							mode_q <= ST_BON;
							bcnt_q <= '0;
						end
					end
					ST_BON: begin
						// pulse count not limited: burst-on ends on pause/exit feedback, count only steps the peak
						if (cyc_end) bcnt_q <= bcnt_q + 8'h1; // RQ7
						// feedback falls as the output recovers: pause sits below wake
						if (fb <= pause_th) mode_q <= ST_BOFF; // RQ5
					end
					ST_EXIT: begin
						if (cyc_end) begin // RQ10
							exit_used_q <= 1'b1;
							mode_q      <= ST_NORMAL;
						end
					end
					default: mode_q <= ST_NORMAL;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// peak and jitter
	// ----------------------------------------------------------------
	logic [7:0]  peak_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) peak_q <= BURST_PK0;
		else begin
			case (mode_q)
				ST_BON: begin // RQ8
					case (bcnt_q)
						8'h00:   peak_q <= BURST_PK0;
						8'h01:   peak_q <= BURST_PK1;
						8'h02:   peak_q <= BURST_PK2;
						default: peak_q <= BURST_PK3;
					endcase
				end
				ST_EXIT: peak_q <= EXIT_PK; // RQ10
				default: peak_q <= fb;
			endcase
		end
	end
	assign peak_setting = peak_q;

	// triangular jitter over 3.2 ms: 256 steps of 12.5 us
	logic [15:0] jdiv_q;
	logic [7:0]  jph_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			jdiv_q <= '0;
			jph_q  <= '0;
		end else if (jdiv_q == 16'(JIT_STEP_CYCLES - 1)) begin
			jdiv_q <= '0;
			jph_q  <= jph_q + 8'h1; // RQ2
		end else jdiv_q <= jdiv_q + 16'h1;
	end
	logic [15:0] amp, tri_v, jit_off, per_eff;
	always_comb begin
		amp     = base_per >> JIT_AMP_SHIFT; // RQ2
		tri_v   = jph_q[7] ? {9'h0, ~jph_q[6:0]} : {9'h0, jph_q[6:0]};
		jit_off = 16'((32'(amp) * 32'(tri_v) * 2) >> 7);
		if (mode_q == ST_BON || mode_q == ST_EXIT)
			per_eff = BURST_PERIOD_RST; // RQ8
		else if (jit_en && amax)
			per_eff = base_per - amp + jit_off; // RQ1
		else
			per_eff = base_per;
	end
	logic [15:0] per_q2;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) per_q2 <= PERIOD_RST[15:0];
		else per_q2 <= per_eff;
	end
	assign period_out = per_q2;

	// ----------------------------------------------------------------
	// resonant pulse sequencer
	// ----------------------------------------------------------------
	logic        aux_en_q;
	logic [11:0] bulk_v_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aux_en_q <= 1'b0;
			bulk_v_q <= '0;
		end else begin
			// sense current already scaled by the 102 kohm resistor into volts
			bulk_v_q <= bulk_i; // RQ19
			if (bulk_i >= line_lvl + HYST_VOLTS) aux_en_q <= 1'b1; // RQ15
			else if (bulk_i < line_lvl) aux_en_q <= 1'b0; // RQ15
		end
	end
	// aux length in cycles: bulk*k/65536*15.15 ns + 31.6 ns
	logic [27:0] bk;
	logic [15:0] aux_len;
	always_comb begin
		bk      = 28'(32'(bulk_v_q) * 32'(kfac) >> 16);
		aux_len = 16'((32'(bk) * AUX_STEP_PS) / CLK_PS) + 16'(AUX_BASE_CYC); // RQ17
	end

	fbz_phase_t  ph_q;
	logic [15:0] pcnt_q, tcnt_q;
	wire logic   gating = (mode_q == ST_NORMAL) || (mode_q == ST_BON) || (mode_q == ST_EXIT);
	assign cyc_end = (ph_q == PH_MAIN) && (pcnt_q == '0);
	logic main_q, aux_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ph_q   <= PH_IDLE;
			pcnt_q <= '0;
			tcnt_q <= '0;
			main_q <= 1'b0;
			aux_q  <= 1'b0;
		end else begin
			// period counter sets the main switching period directly
			tcnt_q <= (tcnt_q >= per_q2 - 16'h1) ? '0 : tcnt_q + 16'h1; // RQ12
			if (!gating) begin
				ph_q   <= PH_IDLE; // RQ20
				main_q <= 1'b0;
				aux_q  <= 1'b0;
			end else begin
				case (ph_q)
					PH_IDLE: if (tcnt_q == '0) ph_q <= PH_WAITZC;
					PH_WAITZC: begin
						if (zc) begin // RQ14
							ph_q   <= (res_en && aux_en_q) ? PH_ZDLY : PH_MAIN;
							pcnt_q <= (res_en && aux_en_q) ? zc_dly : {8'h0, peak_q};
							main_q <= !(res_en && aux_en_q);
						end
					end
					PH_ZDLY: begin
						if (pcnt_q == '0) begin // RQ13
							ph_q   <= PH_AUX;
							pcnt_q <= aux_len;
							aux_q  <= 1'b1; // RQ11
						end else pcnt_q <= pcnt_q - 16'h1;
					end
					PH_AUX: begin
						if (pcnt_q <= 16'h1) begin
							ph_q   <= PH_DEAD;
							pcnt_q <= 16'(DEAD_CYC - 1);
							aux_q  <= 1'b0;
						end else pcnt_q <= pcnt_q - 16'h1;
					end
					PH_DEAD: begin
						if (pcnt_q == '0) begin // RQ16
							ph_q   <= PH_MAIN;
							pcnt_q <= {8'h0, peak_q};
							main_q <= 1'b1; // RQ11
						end else pcnt_q <= pcnt_q - 16'h1;
					end
					PH_MAIN: begin
						if (pcnt_q == '0) begin
							ph_q   <= PH_IDLE;
							main_q <= 1'b0;
						end else pcnt_q <= pcnt_q - 16'h1;
					end
					default: ph_q <= PH_IDLE;
				endcase
			end
		end
	end
	assign main_gate_output = main_q;
	assign aux_gate_output  = aux_q;

	always_comb begin
		st_word = {bcnt_q, 6'h0, exit_used_q, aux_en_q, 1'b0, ph_q, 1'b0, mode_q, 1'b0,
			JIT_PER_CODE[2:0], 1'b0, JIT_AMP_CODE[2:0]};
	end
endmodule

// *** testbench/fbz_gate_sva.sv ***
`timescale 1ns/1ps
// ----
// gate timing and bus handshake checks
// ----
module fbz_gate_sva import fbz_pkg::*; (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// bus handshake
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	// pins
	input wire logic       zero_cross,
	input wire logic       main_gate_output,
	input wire logic       aux_gate_output,
	input wire logic [7:0] peak_setting
);
	logic [7:0] dead_q;
	logic [7:0] mlen_q;
	logic [7:0] alen_q;
	logic       mg_q;
	logic [7:0] pk_d_q;
	logic [7:0] pk_rise_q;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// dead count saturates so a pulse without aux is told apart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dead_q <= 8'hff;
			mlen_q <= 8'h00;
			alen_q <= 8'h00;
			mg_q      <= 1'b0;
			pk_d_q    <= 8'h00;
			pk_rise_q <= 8'h00;
		end else begin
			// width is fixed by the peak loaded just before the rise; peak may move later
			mg_q   <= main_gate_output;
			pk_d_q <= peak_setting;
			if (main_gate_output && !mg_q) pk_rise_q <= pk_d_q;
			dead_q <= aux_gate_output ? 8'h00 : dead_q + {7'h00, dead_q != 8'hff};
			mlen_q <= main_gate_output ? mlen_q + 8'h01 : 8'h00;
			alen_q <= aux_gate_output ? alen_q + 8'h01 : 8'h00;
		end
	end

	a_gates_exclusive: assert property (
		!(main_gate_output && aux_gate_output)) else $error("both gates high");
	a_dead_exact: assert property (
		$rose(main_gate_output) && dead_q != 8'hff |-> dead_q == 8'(DEAD_CYC))
		else $error("dead time wrong");
	a_main_after_zc: assert property (
		$rose(main_gate_output) |-> $past(zero_cross, 3)) else $error("main without crossing");
	a_aux_after_zc: assert property (
		$rose(aux_gate_output) |-> $past(zero_cross, 3)) else $error("aux without crossing");
	a_main_width: assert property (
		$fell(main_gate_output) |-> mlen_q == pk_rise_q + 8'h01)
		else $error("main width wrong");
	a_aux_min_len: assert property (
		$fell(aux_gate_output) |-> alen_q >= 8'(AUX_BASE_CYC)) else $error("aux too short");
	a_ack_answer: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule

// *** testbench/fbz_stage_model.sv ***
`timescale 1ns/1ps
// ----
// power stage: crossing returns after demagnetisation
// ----
module fbz_stage_model (
	// clock
	input  wire logic       clk,
	// gate and demagnetisation time in cycles
	input  wire logic       main_gate,
	input  wire logic [9:0] demag,
	// crossing level
	output logic            zero_cross
);
	logic [9:0] left_q = 10'h000;

	initial zero_cross = 1'b1;
	// no crossing while the switch conducts, nor until demag has run out
	always @(posedge clk) begin
		left_q <= main_gate ? demag : left_q - {9'h000, left_q != 10'h000};
		zero_cross <= !main_gate && left_q == 10'h000;
	end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top import fbz_pkg::*; ;
	typedef struct {logic [7:0] a; logic [31:0] v;} fbz_reg_row_t;
	typedef struct {logic [31:0] c; logic [11:0] b; logic x; logic e;} fbz_gate_row_t;
	localparam int WAKE_T = 20;
	// ----
	// pins and bookkeeping
	// ----
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [7:0]  feedback_pin = 8'h80;
	logic [7:0]  zcd_level = 8'hc0;
	logic        zero_cross;
	logic [11:0] bulk_sense_pin = 12'h140;
	logic        at_max_freq = 1'b0;
	logic        main_gate_output;
	logic        aux_gate_output;
	logic [7:0]  peak_setting;
	logic [15:0] period_out;
	logic [15:0] pmin;
	logic [15:0] pmax;
	logic [7:0]  pks[$];
	logic        mg_d = 1'b0;
	logic        ag_d = 1'b0;
	int          cyc = 0;
	int          n_main, n_aux, t_main, d_main, t_first, t0;
	int          miscompares = 0;
	int          checks_done = 0;
	fbz_reg_row_t  regs[6] = '{'{REG_CTRL, CTRL_RST}, '{REG_THRESH, THRESH_RST},
		'{REG_PERIOD, PERIOD_RST}, '{REG_ZVS, 32'h0000_0c80}, '{REG_LINE, LINE_RST},
		'{8'h18, 32'h0}};
	fbz_gate_row_t gates[3] = '{'{32'h1, 12'h140, 1'b1, 1'b1},
		'{32'h1, 12'h050, 1'b0, 1'b0}, '{32'h0, 12'h140, 1'b0, 1'b1}};
	logic [7:0]  exp_pk[5] = '{BURST_PK0, BURST_PK1, BURST_PK2, BURST_PK3, BURST_PK3};

	always #4 clk = ~clk;

	fbz_gate_ctrl #(
		.WAKE_CYCLES     (WAKE_T),
		.JIT_STEP_CYCLES (4)
	) uut (
		.clk              (clk),
		.rst_n            (rst_n),
		.wb_cyc_i         (wb_cyc_i),
		.wb_stb_i         (wb_stb_i),
		.wb_we_i          (wb_we_i),
		.wb_adr_i         (wb_adr_i),
		.wb_sel_i         (4'hf),
		.wb_dat_i         (wb_dat_i),
		.wb_dat_o         (wb_dat_o),
		.wb_ack_o         (wb_ack_o),
		.feedback_pin     (feedback_pin),
		.zcd_level        (zcd_level),
		.zero_cross       (zero_cross),
		.bulk_sense_pin   (bulk_sense_pin),
		.at_max_freq      (at_max_freq),
		.main_gate_output (main_gate_output),
		.aux_gate_output  (aux_gate_output),
		.peak_setting     (peak_setting),
		.period_out       (period_out)
	);

	fbz_stage_model u_stage (
		.clk        (clk),
		.main_gate  (main_gate_output),
		.demag      (10'h028),
		.zero_cross (zero_cross)
	);

	// ----
	// gate monitor
	// ----
	always @(posedge clk) begin
		cyc <= cyc + 1;
		mg_d <= main_gate_output;
		ag_d <= aux_gate_output;
		if (main_gate_output === 1'b1 && mg_d === 1'b0) begin
			if (pks.size() == 0) t_first <= cyc;
			pks.push_back(peak_setting);
			n_main <= n_main + 1;
			d_main <= cyc - t_main;
			t_main <= cyc;
		end
		if (aux_gate_output === 1'b1 && ag_d === 1'b0) n_aux <= n_aux + 1;
	end

	// ----
	// tasks
	// ----
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(string w, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic span(int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wb(logic we, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// look at ack between edges, release just after the edge that samples it
		@(negedge clk);
		while (wb_ack_o !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (n == 50) chk("ack", 1, 0);
		q = wb_dat_o;
		@(posedge clk);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic mode_chk(logic [2:0] m);
		logic [31:0] q;
		wb(1'b0, REG_STATUS, 32'h0, q);
		chk("mode", m, q[10:8]);
	endtask

	task automatic watch(int n);
		pmin = 16'hffff;
		pmax = 16'h0000;
		repeat (n) begin
			@(negedge clk);
			if (period_out < pmin) pmin = period_out;
			if (period_out > pmax) pmax = period_out;
		end
		@(posedge clk);
	endtask

	// wait until a main pulse has just ended, so a mode change cannot cut one short
	task automatic gap;
		int k;
		k = 0;
		while (main_gate_output !== 1'b1 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		while (main_gate_output !== 1'b0 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		@(posedge clk);
	endtask

	task automatic wait_pk(int n);
		int k;
		k = 0;
		while (pks.size() < n && k < 20000) begin
			@(posedge clk);
			k++;
		end
	endtask

	initial begin
		span(60000);
		miscompares++;
		report_and_stop;
	end

	// ----
	// main sequence
	// ----
	initial begin
		logic [31:0] q;
		span(20);
		rst_n <= 1'b1;
		span(3);
		foreach (regs[i]) begin
			wb(1'b0, regs[i].a, 32'h0, q);
			chk("register reset", regs[i].v, q);
		end
		wb(1'b1, 8'h18, 32'hffff_ffff, q);
		wb(1'b0, 8'h18, 32'h0, q);
		chk("unmapped", 32'h0, q);
		wb(1'b1, REG_STATUS, 32'h0, q);
		wb(1'b0, REG_STATUS, 32'h0, q);
		chk("amp code", 3'h5, q[2:0]);
		chk("period code", 3'h3, q[6:4]);
		$display("test registers done");
		wb(1'b1, REG_CTRL, 32'h3, q);
		watch(200);
		chk("jitter off", {16'h0382, 16'h0382}, {pmin, pmax});
		at_max_freq <= 1'b1;
		span(30);
		watch(1100);
		chk("jitter bound", 1, pmax <= 16'h039f && pmin >= 16'h0365);
		chk("jitter span", 1, pmax - pmin >= 16'd54);
		at_max_freq <= 1'b0;
		$display("test jitter done");
		foreach (gates[i]) begin
			wb(1'b1, REG_CTRL, gates[i].c, q);
			bulk_sense_pin <= gates[i].b;
			span(1000);
			wb(1'b0, REG_STATUS, 32'h0, q);
			chk("aux enable", gates[i].e, q[16]);
			gap;
			n_main = 0;
			n_aux = 0;
			span(4000);
			chk("main pulses", 1, n_main >= 3);
			chk("aux pulses", gates[i].x ? n_main : 0, n_aux);
			chk("main period", 32'h382, d_main);
		end
		$display("test gates done");
		feedback_pin <= 8'h20;
		span(200);
		mode_chk(ST_NORMAL);
		gap;
		zcd_level <= 8'h00;
		span(200);
		mode_chk(ST_BOFF);
		n_main = 0;
		n_aux = 0;
		span(2000);
		chk("quiet off phase", 0, n_main + n_aux);
		pks.delete();
		t0 = cyc;
		feedback_pin <= 8'hb0;
		wait_pk(2);
		feedback_pin <= 8'h90;
		wait_pk(5);
		chk("wake delay", 1, t_first - t0 >= WAKE_T);
		chk("burst period", 32'h320, d_main);
		foreach (exp_pk[i]) chk("burst peak", exp_pk[i], pks[i]);
		gap;
		feedback_pin <= 8'h28;
		span(50);
		mode_chk(ST_BOFF);
		pks.delete();
		feedback_pin <= 8'hd0;
		span(10);
		mode_chk(ST_EXIT);
		wait_pk(1);
		chk("exit peak", EXIT_PK, pks[0]);
		$display("test burst done");
		report_and_stop;
	end
endmodule

bind fbz_gate_ctrl fbz_gate_sva u_sva (
	.clk              (clk),
	.rst_n            (rst_n),
	.wb_cyc_i         (wb_cyc_i),
	.wb_stb_i         (wb_stb_i),
	.wb_ack_o         (wb_ack_o),
	.zero_cross       (zero_cross),
	.main_gate_output (main_gate_output),
	.aux_gate_output  (aux_gate_output),
	.peak_setting     (peak_setting)
);
